// ---- hw/adc_mux_ctrl.sv ----
// Input mux, burnout source and offset cancellation control with an AXI4-Lite register slave.
// What this block does
// - Upper nibble selects positive, lower selects negative.
// - Scan mode drives selectors from scan channel code.
// - Code 0xde presents the temperature diode pair.
// - Burnout field decodes off or three currents.
// - Burnout stays on regardless of conversion state.
// - Diode selection gates burnout, enables diode bias.
// - Auto-zero cleared means plain single conversions.
// - Auto-zero takes two conversions, second inputs swapped.
// - Auto-zero doubles time; ready after both conversions.
// - Continuous auto-zero resets filter between conversions.
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`include "adc_mux_defs.svh"

module adc_mux_ctrl
    import adc_mux_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_s_axi_awvalid,
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_wvalid,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_bready,
    input wire logic i_s_axi_arvalid,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic i_s_axi_rready,
    input wire logic i_scan_active,
    input wire logic [7:0] i_scan_code,
    input wire logic i_conv_done,
    input wire logic [23:0] i_conv_data,
    output logic o_s_axi_awready,
    output logic o_s_axi_wready,
    output logic o_s_axi_bvalid,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_arready,
    output logic o_s_axi_rvalid,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output analog_ctrl_type o_analog,
    output logic o_conv_start,
    output logic o_filter_reset,
    output logic [23:0] o_result,
    output logic o_result_valid
);

    // Present state and its next value.
    ctrl_state_type st_reg;
    ctrl_state_type st_next;
    // Offset-free result formed from the stored first conversion and the live second one.
    logic [23:0] az_word;
    // Selector code in force for the coming cycle.
    logic [7:0] sel;

    // True when a selector code pairs the two temperature diodes.
    function automatic logic is_diode_pair(input logic [7:0] code);
        is_diode_pair = (code == `SEL_DIODE_PAIR);
    endfunction

    az_result_calc u_az_calc (
        .i_straight(st_reg.first),
        .i_swapped(i_conv_data),
        .o_result(az_word)
    );

    // Next-state logic: bus slave first, then the sequencer, then the front-end settings.
    always_comb begin
        st_next = st_reg;
        st_next.conv_start = 1'b0;
        st_next.filter_reset = 1'b0;
        st_next.result_valid = 1'b0;
        sel = 8'h00;
        // Address and data may arrive in either order; each is latched on its own.
        if (i_s_axi_awvalid && st_reg.awready) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && st_reg.wready) begin
            st_next.w_got = 1'b1;
            st_next.wdata = i_s_axi_wdata;
            st_next.wstrb = i_s_axi_wstrb;
        end
        if (st_reg.bvalid && i_s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        // Both halves present: perform the write; every field sits in byte lane zero.
        if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = `RESP_OKAY;
            unique case ({st_reg.awaddr[7:2], 2'b00})
                `OFS_CFG_ZERO: begin
                    // The burnout field may be rewritten at any time, even mid-conversion.
                    if (st_reg.wstrb[0]) st_next.burnout_field = st_reg.wdata[1:0];
                end
                `OFS_CFG_TWO: begin
                    if (st_reg.wstrb[0]) st_next.az_en = st_reg.wdata[`FLD_AZ_EN];
                end
                `OFS_INPUT_SEL: begin
                    if (st_reg.wstrb[0]) st_next.input_select = st_reg.wdata[7:0];
                end
                `OFS_CONV_CTRL: begin
                    if (st_reg.wstrb[0]) begin
                        st_next.conversion_mode_field = st_reg.wdata[1:0];
                        st_next.start_req = st_reg.start_req | st_reg.wdata[`FLD_START];
                    end
                end
                `OFS_STATUS, `OFS_RESULT: begin
                    // Read-only registers ignore writes but answer normally.
                    st_next.bresp = `RESP_OKAY;
                end
                default: begin
                    st_next.bresp = `RESP_SLVERR;
                end
            endcase
        end
        // Ready is withheld while a write is pending so only one write is under way.
        st_next.awready = !st_next.aw_got && !st_next.bvalid;
        st_next.wready = !st_next.w_got && !st_next.bvalid;
        // Read channel: the answer follows one cycle after the address is taken.
        if (st_reg.rvalid && i_s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (i_s_axi_arvalid && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = `RESP_OKAY;
            st_next.rdata = 32'h0000_0000;
            unique case ({i_s_axi_araddr[7:2], 2'b00})
                `OFS_CFG_ZERO: st_next.rdata[1:0] = st_reg.burnout_field;
                `OFS_CFG_TWO: st_next.rdata[`FLD_AZ_EN] = st_reg.az_en;
                `OFS_INPUT_SEL: st_next.rdata[7:0] = st_reg.input_select;
                `OFS_CONV_CTRL: st_next.rdata[1:0] = st_reg.conversion_mode_field;
                `OFS_STATUS: begin
                    st_next.rdata[`FLD_READY] = st_reg.data_ready;
                    st_next.rdata[`FLD_BUSY] = (st_reg.phase != CONV_IDLE);
                end
                `OFS_RESULT: begin
                    st_next.rdata[23:0] = st_reg.result;
                    // Reading the result clears the ready flag; a new result below still wins.
                    st_next.data_ready = 1'b0;
                end
                default: st_next.rresp = `RESP_SLVERR;
            endcase
        end
        st_next.arready = !st_next.rvalid;
        // Conversion sequencer; the converter itself times each conversion.
        unique case (st_reg.phase)
            CONV_IDLE: begin
                if (st_reg.start_req || st_reg.conversion_mode_field == `MODE_CONT) begin
                    st_next.start_req = 1'b0;
                    st_next.conv_start = 1'b1;
                    st_next.phase = CONV_FIRST;
                end
            end
            CONV_FIRST: begin
                if (i_conv_done && st_reg.az_en) begin
                    // Keep the straight result and start the swapped one from a clean filter.
                    st_next.first = i_conv_data;
                    st_next.conv_start = 1'b1;
                    st_next.filter_reset = 1'b1;
                    st_next.phase = CONV_SECOND;
                end else if (i_conv_done) begin
                    st_next.result = i_conv_data;
                    st_next.result_valid = 1'b1;
                    st_next.data_ready = 1'b1;
                    // Plain continuous mode keeps the converter running without restarts.
                    if (st_reg.conversion_mode_field != `MODE_CONT) st_next.phase = CONV_IDLE;
                end
            end
            CONV_SECOND: begin
                if (i_conv_done) begin
                    st_next.result = az_word;
                    st_next.result_valid = 1'b1;
                    st_next.data_ready = 1'b1;
                    if (st_reg.conversion_mode_field == `MODE_CONT) begin
                        // Continuous becomes back-to-back one-shots, each from a reset filter.
                        st_next.conv_start = 1'b1;
                        st_next.filter_reset = 1'b1;
                        st_next.phase = CONV_FIRST;
                    end else begin
                        st_next.phase = CONV_IDLE;
                    end
                end
            end
        endcase
        // Scan sequencing overrides the software selector code.
        sel = i_scan_active ? i_scan_code : st_next.input_select;
        // The swapped phase exchanges the two selectors.
        if (st_next.phase == CONV_SECOND) begin
            st_next.analog.pos = sel[3:0];
            st_next.analog.neg = sel[7:4];
        end else begin
            st_next.analog.pos = sel[7:4];
            st_next.analog.neg = sel[3:0];
        end
        // The diode pair gets its own bias; the stored burnout field is left untouched.
        st_next.analog.diode_bias = is_diode_pair(sel);
        // Burnout does not depend on the sequencer, so it stays on while idle or converting.
        st_next.analog.burnout = is_diode_pair(sel) ? 2'h0 : st_next.burnout_field;
    end

    // State register with synchronous reset.
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            st_reg <= '0;
            st_reg.burnout_field <= `RST_BURNOUT;
            st_reg.az_en <= `RST_AZ_EN;
            st_reg.input_select <= `RST_INPUT_SEL;
            st_reg.conversion_mode_field <= `RST_CONVERSION_MODE_FIELD;
            // Selectors follow the reset select code at once, so no stale pairing shows after reset.
            {st_reg.analog.pos, st_reg.analog.neg} <= `RST_INPUT_SEL;
        end else begin
            st_reg <= st_next;
        end
    end

    // Every output is a field of the state register.
    assign o_s_axi_awready = st_reg.awready;
    assign o_s_axi_wready = st_reg.wready;
    assign o_s_axi_bvalid = st_reg.bvalid;
    assign o_s_axi_bresp = st_reg.bresp;
    assign o_s_axi_arready = st_reg.arready;
    assign o_s_axi_rvalid = st_reg.rvalid;
    assign o_s_axi_rdata = st_reg.rdata;
    assign o_s_axi_rresp = st_reg.rresp;
    assign o_analog = st_reg.analog;
    assign o_conv_start = st_reg.conv_start;
    assign o_filter_reset = st_reg.filter_reset;
    assign o_result = st_reg.result;
    assign o_result_valid = st_reg.result_valid;

    // Straight phase outside scan uses upper nibble as positive.
    a_straight_select: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (!$past(i_scan_active) && st_reg.phase != CONV_SECOND)
        |-> ({st_reg.analog.pos, st_reg.analog.neg} == st_reg.input_select))
        else $error("Straight selector does not follow the input select field.");

    // Scan code takes over the selectors.
    a_scan_select: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        ($past(i_scan_active) && st_reg.phase != CONV_SECOND)
        |-> ({st_reg.analog.pos, st_reg.analog.neg} == $past(i_scan_code)))
        else $error("Scan code was not applied to the selectors.");

    // Diode bias exactly when the diode pair is selected.
    a_diode_pair: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        st_reg.analog.diode_bias == (((st_reg.phase == CONV_SECOND) ? {st_reg.analog.neg, st_reg.analog.pos}
        : {st_reg.analog.pos, st_reg.analog.neg}) == `SEL_DIODE_PAIR))
        else $error("Diode bias does not match the diode pair selection.");

    // Burnout follows its field regardless of the sequencer unless the diodes gate it.
    a_burnout_level: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        st_reg.analog.burnout == (st_reg.analog.diode_bias ? 2'h0 : st_reg.burnout_field))
        else $error("Burnout output disagrees with its field or the diode gate.");

    // Swapped phase exchanges the selectors.
    a_swap_second: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (!$past(i_scan_active) && st_reg.phase == CONV_SECOND)
        |-> ({st_reg.analog.neg, st_reg.analog.pos} == st_reg.input_select))
        else $error("Second conversion did not swap the inputs.");

    // Without auto-zero a result is the raw conversion.
    a_plain_result: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (st_reg.result_valid && $past(st_reg.phase) == CONV_FIRST)
        |-> (!$past(st_reg.az_en) && st_reg.result == $past(i_conv_data)))
        else $error("Plain result differs from the conversion data.");

    // First auto-zero conversion does not report a result.
    a_az_two_conv: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (st_reg.phase == CONV_FIRST && st_reg.az_en && i_conv_done)
        |=> (!st_reg.result_valid && st_reg.phase == CONV_SECOND && st_reg.conv_start))
        else $error("Auto-zero reported after one conversion.");

    // Auto-zero result is the halved signed difference.
    a_az_half_diff: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (st_reg.result_valid && $past(st_reg.phase) == CONV_SECOND)
        |-> ($signed(st_reg.result) == 24'(($signed({$past(st_reg.first[23]), $past(st_reg.first)})
        - $signed({$past(i_conv_data[23]), $past(i_conv_data)})) >>> 1)))
        else $error("Auto-zero result is not half the difference.");

    // Continuous auto-zero restarts from a reset filter.
    a_cont_filter_reset: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (st_reg.phase == CONV_SECOND && i_conv_done && st_reg.conversion_mode_field == `MODE_CONT)
        |=> (st_reg.filter_reset && st_reg.conv_start && st_reg.result_valid ##1 !st_reg.filter_reset))
        else $error("Continuous auto-zero did not reset the filter.");

endmodule

// ---- hw/adc_mux_defs.svh ----
// Register offsets, field positions, reset values and codes of the input mux control block.
`ifndef ADC_MUX_DEFS_SVH
`define ADC_MUX_DEFS_SVH

// Register byte offsets on the control bus.
`define OFS_CFG_ZERO 8'h00
`define OFS_CFG_TWO 8'h04
`define OFS_INPUT_SEL 8'h08
`define OFS_CONV_CTRL 8'h0c
`define OFS_STATUS 8'h10
`define OFS_RESULT 8'h14

// Field positions inside the registers.
`define FLD_AZ_EN 0
`define FLD_START 2
`define FLD_READY 0
`define FLD_BUSY 1

// Reset values of the software fields.
`define RST_BURNOUT 2'h0
`define RST_AZ_EN 1'h0
`define RST_INPUT_SEL 8'h01
`define RST_CONVERSION_MODE_FIELD 2'h0

// Codes of the selector and the conversion mode field.
`define SEL_DIODE_PAIR 8'hde
`define SEL_DIODE_P 4'hd
`define SEL_DIODE_M 4'he
`define MODE_CONT 2'h3

// Bus answers.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- hw/adc_mux_pkg.sv ----
// Types shared by the input mux control block and its result arithmetic.
package adc_mux_pkg;

    // Phase of the conversion sequencer.
    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_FIRST,
        CONV_SECOND
    } conv_phase_type;

    // Settings driven into the analog front end.
    typedef struct packed {
        logic [3:0] pos;
        logic [3:0] neg;
        logic [1:0] burnout;
        logic diode_bias;
    } analog_ctrl_type;

    // Whole state of the control block.
    typedef struct packed {
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [1:0] burnout_field;
        logic az_en;
        logic [7:0] input_select;
        logic [1:0] conversion_mode_field;
        logic start_req;
        logic data_ready;
        logic [23:0] first;
        logic [23:0] result;
        logic result_valid;
        logic conv_start;
        logic filter_reset;
        conv_phase_type phase;
        analog_ctrl_type analog;
    } ctrl_state_type;

endpackage

// ---- hw/az_result_calc.sv ----
// Combines the straight and the swapped conversion into one offset-free result.
module az_result_calc
    import adc_mux_pkg::*;
(
    input wire logic [23:0] i_straight,
    input wire logic [23:0] i_swapped,
    output logic [23:0] o_result
);

    // Signed difference halved; the extra bit keeps the subtraction from wrapping.
    function automatic logic [23:0] half_diff(input logic [23:0] a, input logic [23:0] b);
        logic signed [24:0] d;
        d = $signed({a[23], a}) - $signed({b[23], b});
        half_diff = d[24:1];
    endfunction

    // The 24-bit output format is kept as is.
    assign o_result = half_diff(i_straight, i_swapped);

endmodule

// ---- test/conv_model.sv ----
// Behavioural converter that answers conversion starts from the mux control block.
module conv_model
    import adc_mux_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_conv_start,
    input wire analog_ctrl_type i_analog,
    input wire logic [3:0] i_delay,
    input wire logic i_free_run,
    output logic o_conv_done,
    output logic [23:0] o_conv_data
);
    timeunit 1ns;
    timeprecision 1ns;

    logic busy_reg; // A conversion is under way.
    logic [3:0] cnt_reg; // Cycles left before the answer.

    // The code depends on both selectors unevenly, so a missed swap shows up in the result.
    // The data line toggles outside the done pulse, since a stale value would hide late sampling.
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            busy_reg <= 1'b0;
            cnt_reg <= 4'h0;
            o_conv_done <= 1'b0;
            o_conv_data <= 24'h0;
        end else begin
            o_conv_done <= 1'b0;
            o_conv_data <= ~o_conv_data;
            if (i_conv_start) begin
                busy_reg <= 1'b1;
                cnt_reg <= i_delay;
            end else if (busy_reg && cnt_reg == 4'h0) begin
                // A free-running converter reloads itself, as in plain continuous mode.
                busy_reg <= i_free_run;
                cnt_reg <= i_delay;
                o_conv_done <= 1'b1;
                o_conv_data <= 24'(int'(i_analog.pos) * 1000 - int'(i_analog.neg) * 999 + 77);
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end
endmodule

// ---- test/testbench.sv ----
// Self-checking bench of the input mux control block with a converter model.
`include "adc_mux_defs.svh"

module testbench
    import adc_mux_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk, nrst, awvalid, wvalid, bready, arvalid, rready, scan_active, conv_done, free_run;
    logic awready, wready, bvalid, arready, rvalid, conv_start, filter_reset, result_valid;
    logic [7:0] awaddr, araddr, scan_code;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, conv_delay;
    logic [1:0] bresp, rresp;
    logic [23:0] conv_data, result;
    analog_ctrl_type analog;
    int errors, num_checks, bc, bf, br;
    // Pulse totals; only the monitor below updates them.
    int n_cs = 0, n_fr = 0, n_rv = 0;

    // The clock runs at 25 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    adc_mux_ctrl dut_u (.i_sys_clk(sys_clk), .i_nrst(nrst), .i_s_axi_awvalid(awvalid),
        .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
        .i_s_axi_bready(bready), .i_s_axi_arvalid(arvalid), .i_s_axi_araddr(araddr),
        .i_s_axi_rready(rready), .i_scan_active(scan_active), .i_scan_code(scan_code),
        .i_conv_done(conv_done), .i_conv_data(conv_data), .o_s_axi_awready(awready),
        .o_s_axi_wready(wready), .o_s_axi_bvalid(bvalid), .o_s_axi_bresp(bresp),
        .o_s_axi_arready(arready), .o_s_axi_rvalid(rvalid), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_analog(analog), .o_conv_start(conv_start),
        .o_filter_reset(filter_reset), .o_result(result), .o_result_valid(result_valid));

    conv_model conv_u (.i_sys_clk(sys_clk), .i_nrst(nrst), .i_conv_start(conv_start), .i_analog(analog),
        .i_delay(conv_delay), .i_free_run(free_run), .o_conv_done(conv_done), .o_conv_data(conv_data));

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_an(input analog_ctrl_type got, input analog_ctrl_type exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Pulses are counted by non-blocking updates so the main sequence reads settled totals.
    always @(posedge sys_clk) begin
        if (conv_start) n_cs <= n_cs + 1;
        if (result_valid) n_rv <= n_rv + 1;
        if (filter_reset) begin
            n_fr <= n_fr + 1;
            chk_word(32'(conv_start), 32'h1);
        end
    end

    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
    endtask

    // One write; address and data are released each at its own handshake.
    // No wait here has a limit of its own: a hung bus is ended by the watchdog as a mismatch.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk_word(32'(bresp), 32'(er));
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge sys_clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk_word(rdata, ed);
        chk_word(32'(rresp), 32'(er));
    endtask

    // Waits for the result pulse; the result register is loaded on the same edge.
    task automatic wait_res(input logic [23:0] exp);
        do begin
            @(posedge sys_clk);
        end while (result_valid !== 1'b1);
        chk_word(32'(result), 32'(exp));
    endtask

    function automatic logic [23:0] plain(input int p, input int n);
        return 24'(p * 1000 - n * 999 + 77);
    endfunction

    // Offset cancels in the difference; the odd difference exercises the arithmetic shift.
    function automatic logic [23:0] azr(input int p, input int n);
        return 24'((1999 * (p - n)) >>> 1);
    endfunction

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog far beyond the few hundred cycles the tests take.
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        end_sim();
    end

    // Only channel codes bonded out on every variant are driven.
    initial begin
        errors = 0;
        num_checks = 0;
        nrst = 1'b0;
        awvalid = 1'b0;
        awaddr = 8'h0;
        wvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'hf;
        bready = 1'b0;
        arvalid = 1'b0;
        araddr = 8'h0;
        rready = 1'b0;
        scan_active = 1'b0;
        scan_code = 8'h0;
        conv_delay = 4'h6;
        free_run = 1'b0;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        tick(2);
        chk_an(analog, '{4'h0, 4'h1, 2'h0, 1'b0});
        axi_rd(`OFS_INPUT_SEL, 32'h1, `RESP_OKAY);
        axi_rd(`OFS_CFG_ZERO, 32'h0, `RESP_OKAY);
        axi_rd(`OFS_CFG_TWO, 32'h0, `RESP_OKAY);
        axi_rd(8'h18, 32'h0, `RESP_SLVERR);
        axi_wr(8'h18, 32'hff, `RESP_SLVERR);
        $display("test reset done");
        axi_wr(`OFS_INPUT_SEL, 32'h91, `RESP_OKAY);
        for (int b = 0; b < 4; b++) begin
            axi_wr(`OFS_CFG_ZERO, 32'(b), `RESP_OKAY);
            tick(2);
            chk_an(analog, '{4'h9, 4'h1, 2'(b), 1'b0});
        end
        axi_wr(`OFS_INPUT_SEL, 32'(`SEL_DIODE_PAIR), `RESP_OKAY);
        tick(2);
        chk_an(analog, '{`SEL_DIODE_P, `SEL_DIODE_M, 2'h0, 1'b1});
        axi_rd(`OFS_CFG_ZERO, 32'h3, `RESP_OKAY);
        axi_wr(`OFS_INPUT_SEL, 32'h1c, `RESP_OKAY);
        tick(2);
        chk_an(analog, '{4'h1, 4'hc, 2'h3, 1'b0});
        scan_active <= 1'b1;
        scan_code <= 8'h8b;
        tick(2);
        chk_an(analog, '{4'h8, 4'hb, 2'h3, 1'b0});
        scan_code <= `SEL_DIODE_PAIR;
        tick(2);
        chk_an(analog, '{`SEL_DIODE_P, `SEL_DIODE_M, 2'h0, 1'b1});
        scan_active <= 1'b0;
        tick(2);
        chk_an(analog, '{4'h1, 4'hc, 2'h3, 1'b0});
        $display("test selectors done");
        axi_wr(`OFS_INPUT_SEL, 32'h91, `RESP_OKAY);
        bc = n_cs;
        axi_wr(`OFS_CONV_CTRL, 32'h4, `RESP_OKAY);
        tick(3);
        chk_an(analog, '{4'h9, 4'h1, 2'h3, 1'b0});
        // Mid-conversion the status shows busy and no data yet.
        axi_rd(`OFS_STATUS, 32'h2, `RESP_OKAY);
        wait_res(plain(9, 1));
        tick(2);
        chk_word(32'(n_cs - bc), 32'h1);
        axi_rd(`OFS_STATUS, 32'h1, `RESP_OKAY);
        axi_rd(`OFS_RESULT, {8'h0, plain(9, 1)}, `RESP_OKAY);
        axi_rd(`OFS_STATUS, 32'h0, `RESP_OKAY);
        $display("test plain done");
        axi_wr(`OFS_CFG_TWO, 32'h1, `RESP_OKAY);
        for (int i = 0; i < 2; i++) begin
            conv_delay <= (i == 0) ? 4'h1 : 4'h9;
            axi_wr(`OFS_INPUT_SEL, (i == 0) ? 32'h91 : 32'h1c, `RESP_OKAY);
            bc = n_cs;
            bf = n_fr;
            br = n_rv;
            axi_wr(`OFS_CONV_CTRL, 32'h4, `RESP_OKAY);
            wait_res((i == 0) ? azr(9, 1) : azr(1, 12));
            tick(2);
            chk_word(32'(n_cs - bc), 32'h2);
            chk_word(32'(n_fr - bf), 32'h1);
            chk_word(32'(n_rv - br), 32'h1);
        end
        $display("test auto zero done");
        conv_delay <= 4'h2;
        bc = n_cs;
        bf = n_fr;
        br = n_rv;
        axi_wr(`OFS_CONV_CTRL, 32'(`MODE_CONT), `RESP_OKAY);
        repeat (3) wait_res(azr(1, 12));
        axi_wr(`OFS_CONV_CTRL, 32'h0, `RESP_OKAY);
        tick(40);
        chk_word(32'(n_cs - bc), 32'(2 * (n_rv - br)));
        chk_word(32'(n_fr - bf), 32'(n_cs - bc - 1));
        // Plain continuous: the converter runs free after a single start, with no filter resets.
        axi_wr(`OFS_CFG_TWO, 32'h0, `RESP_OKAY);
        free_run <= 1'b1;
        bc = n_cs;
        bf = n_fr;
        axi_wr(`OFS_CONV_CTRL, 32'(`MODE_CONT), `RESP_OKAY);
        repeat (2) wait_res(plain(1, 12));
        axi_wr(`OFS_CONV_CTRL, 32'h0, `RESP_OKAY);
        free_run <= 1'b0;
        tick(40);
        chk_word(32'(n_cs - bc), 32'h1);
        chk_word(32'(n_fr - bf), 32'h0);
        $display("test continuous done");
        end_sim();
    end
endmodule
